// ==== rtl/gpio_port_pkg.sv ====
package gpio_port_pkg;
  localparam int          PIN_COUNT   = 8;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  // register indices; byte address is four times the index
  localparam int          IDX_VALUE   = 0;
  localparam int          IDX_DIR     = 1;
  localparam int          IDX_OPT     = 2;
  localparam int          IDX_SENS    = 3;
  localparam logic [7:0]  OFFS_VALUE  = 8'(IDX_VALUE * 4);
  localparam logic [7:0]  OFFS_DIR    = 8'(IDX_DIR * 4);
  localparam logic [7:0]  OFFS_OPT    = 8'(IDX_OPT * 4);
  localparam logic [7:0]  OFFS_SENS   = 8'(IDX_SENS * 4);
  // sensitivity field position and encodings
  localparam int          SENS_LSB    = 0;
  localparam int          SENS_W      = 2;
  localparam logic [1:0]  SENS_FALL_LOW = 2'h0;
  localparam logic [1:0]  SENS_RISE     = 2'h1;
  localparam logic [1:0]  SENS_FALL     = 2'h2;
  localparam logic [1:0]  SENS_BOTH     = 2'h3;
  // reset values
  localparam logic [7:0]  RST_VALUE   = 8'h00;
  localparam logic [7:0]  RST_DIR     = 8'h00;
  localparam logic [7:0]  RST_OPT     = 8'h00;
  localparam logic [1:0]  RST_SENS    = 2'h0;
  localparam logic        RST_LEVEL   = 1'b1;
  // bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/ext_irq_if.sv ====
`timescale 1ns/1ps
interface ext_irq_if;
  logic       group_level;
  logic [1:0] sens;
  logic       sens_changed;
  logic       vector_fetch;
  logic       pending;
  modport port_side  (output group_level, output sens, output sens_changed,
                      output vector_fetch, input pending);
  modport sense_side (input group_level, input sens, input sens_changed,
                      input vector_fetch, output pending);
endinterface

// ==== rtl/ext_irq_sense.sv ====
`timescale 1ns/1ps
module ext_irq_sense (
  input  wire logic ref_clk_i,           // cpu clock
  input  wire logic reset_i,             // async reset, active high
  ext_irq_if.sense_side irq              // group level in, request out
);
  import gpio_port_pkg::*;

  // ----------------------------------------
  // event detection on the group level
  // ----------------------------------------
  logic prev_level;
  logic pending;
  logic fell;
  logic rose;
  logic set_req;
  logic clr_req;
  logic next_pending;

  assign fell    = prev_level & ~irq.group_level;
  assign rose    = ~prev_level & irq.group_level;
  assign set_req = (irq.sens == SENS_FALL_LOW) ? (fell | ~irq.group_level) :
                   (irq.sens == SENS_RISE)     ? rose :
                   (irq.sens == SENS_FALL)     ? fell :
                                                 (fell | rose);
  assign clr_req = irq.vector_fetch | irq.sens_changed;
  // an event in the clearing cycle still sets the latch
  assign next_pending = set_req | (pending & ~clr_req);
  assign irq.pending  = pending;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_level <= RST_LEVEL;
      pending    <= 1'b0;
    end else begin
      prev_level <= irq.group_level;
      pending    <= next_pending;
    end
  end

  AST_EVENT_SET: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    set_req |=> pending) else $error("event did not set request latch");
  AST_FETCH_CLEAR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    irq.vector_fetch && !set_req |=> !pending) else $error("fetch did not clear request");
  AST_SENS_CLEAR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    irq.sens_changed && !set_req |=> !pending) else $error("sensitivity change kept request");
endmodule

// ==== rtl/gpio_port.sv ====
`timescale 1ns/1ps
module gpio_port (
  input  wire logic                              ref_clk_i,      // cpu clock, 200 MHz
  input  wire logic                              reset_i,        // async reset, active high
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]  s_axi_awaddr_i,  // write address
  input  wire logic                              s_axi_awvalid_i, // write address valid
  output logic                                   s_axi_awready_o, // write address ready
  input  wire logic [gpio_port_pkg::DATA_W-1:0]  s_axi_wdata_i,   // write data
  input  wire logic [3:0]                        s_axi_wstrb_i,   // byte strobes
  input  wire logic                              s_axi_wvalid_i,  // write data valid
  output logic                                   s_axi_wready_o,  // write data ready
  output logic [1:0]                             s_axi_bresp_o,   // write response
  output logic                                   s_axi_bvalid_o,  // write response valid
  input  wire logic                              s_axi_bready_i,  // write response ready
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]  s_axi_araddr_i,  // read address
  input  wire logic                              s_axi_arvalid_i, // read address valid
  output logic                                   s_axi_arready_o, // read address ready
  output logic [gpio_port_pkg::DATA_W-1:0]       s_axi_rdata_o,   // read data
  output logic [1:0]                             s_axi_rresp_o,   // read response
  output logic                                   s_axi_rvalid_o,  // read data valid
  input  wire logic                              s_axi_rready_i,  // read data ready
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] pin_i,         // pin levels
  output logic [gpio_port_pkg::PIN_COUNT-1:0]    pin_o,           // pin drive value
  output logic [gpio_port_pkg::PIN_COUNT-1:0]    pin_oe_o,        // pin drive enable
  output logic [gpio_port_pkg::PIN_COUNT-1:0]    pull_up_o,       // pull-up enable
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] alt_en_i,      // peripheral claims pin
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] alt_drive_i,   // peripheral drives pin
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] alt_out_i,     // peripheral output value
  input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] alt_od_i,      // peripheral wants open-drain
  output logic [gpio_port_pkg::PIN_COUNT-1:0]    alt_in_o,        // level seen by peripheral
  input  wire logic                              irq_mask_i,      // global interrupt mask
  input  wire logic                              vector_fetch_i,  // cpu fetches the vector
  output logic                                   ext_irq_o        // external interrupt request
);
  import gpio_port_pkg::*;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [PIN_COUNT-1:0] port_latch;
  logic [PIN_COUNT-1:0] direction;
  logic [PIN_COUNT-1:0] option;
  logic [SENS_W-1:0]    sens;
  logic [PIN_COUNT-1:0] pin_sample;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  logic [ADDR_W-1:0]    aw_addr;
  logic                 aw_full;
  logic [7:0]           w_data;
  logic                 w_strb0;
  logic                 w_full;
  logic                 aw_take;
  logic                 w_take;
  logic                 write_fire;
  logic                 wr_aligned;
  logic                 wr_value;
  logic                 wr_dir;
  logic                 wr_opt;
  logic                 wr_sens;
  logic                 wr_mapped;
  logic                 sens_changed;
  logic [SENS_W-1:0]    next_sens;

  assign aw_take    = s_axi_awvalid_i & s_axi_awready_o;
  assign w_take     = s_axi_wvalid_i & s_axi_wready_o;
  assign write_fire = aw_full & w_full & ~s_axi_bvalid_o;
  assign wr_aligned = (aw_addr[1:0] == 2'h0);
  assign wr_value   = write_fire & w_strb0 & (aw_addr == OFFS_VALUE);
  assign wr_dir     = write_fire & w_strb0 & (aw_addr == OFFS_DIR);
  assign wr_opt     = write_fire & w_strb0 & (aw_addr == OFFS_OPT);
  assign wr_sens    = write_fire & w_strb0 & (aw_addr == OFFS_SENS);
  assign wr_mapped  = wr_aligned & ((aw_addr == OFFS_VALUE) | (aw_addr == OFFS_DIR) |
                                    (aw_addr == OFFS_OPT) | (aw_addr == OFFS_SENS));
  assign next_sens    = w_data[SENS_LSB +: SENS_W];
  assign sens_changed = wr_sens & (next_sens != sens);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_addr         <= '0;
      aw_full         <= 1'b0;
      s_axi_awready_o <= 1'b1;
      w_data          <= '0;
      w_strb0         <= 1'b0;
      w_full          <= 1'b0;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr         <= s_axi_awaddr_i;
        aw_full         <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (w_take) begin
        w_data          <= s_axi_wdata_i[7:0];
        w_strb0         <= s_axi_wstrb_i[0];
        w_full          <= 1'b1;
        s_axi_wready_o  <= 1'b0;
      end
      if (write_fire) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        aw_full         <= 1'b0;
        w_full          <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // port registers
  // ----------------------------------------
  // the latch takes every value write with strobe bit 0 set, whatever the direction, so the level is ready
  // before the pin turns to output
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      port_latch <= RST_VALUE;
      direction  <= RST_DIR;
      option     <= RST_OPT;
      sens       <= RST_SENS;
    end else begin
      if (wr_value) begin
        port_latch <= w_data;
      end
      if (wr_dir) begin
        direction <= w_data;
      end
      if (wr_opt) begin
        option <= w_data;
      end
      if (wr_sens) begin
        sens <= next_sens;
      end
    end
  end

  // ----------------------------------------
  // per-pin mode logic
  // ----------------------------------------
  logic [PIN_COUNT-1:0] alt_drv;
  logic [PIN_COUNT-1:0] next_pin_oe;
  logic [PIN_COUNT-1:0] next_pin_out;
  logic [PIN_COUNT-1:0] next_pull;
  logic [PIN_COUNT-1:0] next_alt_in;
  logic [PIN_COUNT-1:0] read_value;
  logic [PIN_COUNT-1:0] irq_pin_en;
  logic [PIN_COUNT-1:0] masked_pin;

  for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
    assign alt_drv[n]      = alt_en_i[n] & alt_drive_i[n];
    assign next_pin_oe[n]  = alt_drv[n]   ? (~alt_od_i[n] | ~alt_out_i[n]) :
                             direction[n] ? (option[n] | ~port_latch[n]) :
                                            1'b0;
    assign next_pin_out[n] = alt_drv[n] ? (~alt_od_i[n] & alt_out_i[n]) :
                                          (direction[n] & option[n] & port_latch[n]);
    assign next_pull[n]    = ~alt_drv[n] & ~direction[n] & option[n];
    assign read_value[n]   = direction[n] ? port_latch[n] :
                             alt_drv[n]   ? alt_out_i[n] :
                                            pin_sample[n];
    assign next_alt_in[n]  = direction[n] ? port_latch[n] : pin_sample[n];
    assign irq_pin_en[n]   = ~direction[n] & option[n];
    assign masked_pin[n]   = pin_sample[n] | ~irq_pin_en[n];

    AST_PP_DRIVE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !alt_drv[n] && direction[n] && option[n]
      |=> pin_oe_o[n] && (pin_o[n] == $past(port_latch[n])))
      else $error("push-pull pin not driving latch");
    AST_OD_DRIVE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !alt_drv[n] && direction[n] && !option[n]
      |=> !pin_o[n] && (pin_oe_o[n] == !$past(port_latch[n])))
      else $error("open-drain pin drive wrong");
    AST_INPUT_FLOAT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !alt_drv[n] && !direction[n] |=> !pin_oe_o[n] && (pull_up_o[n] == $past(option[n])))
      else $error("input pin driven or pull wrong");
    AST_ALT_OVERRIDE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      alt_drv[n] && !alt_od_i[n] |=> pin_oe_o[n] && (pin_o[n] == $past(alt_out_i[n])))
      else $error("peripheral output not forced on pin");
    AST_OD_ALT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      alt_drv[n] && alt_od_i[n]
      |=> !pin_o[n] && (pin_oe_o[n] == !$past(alt_out_i[n])))
      else $error("open-drain peripheral drive wrong");
    AST_ALT_FEED: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      direction[n] |=> alt_in_o[n] == $past(port_latch[n]))
      else $error("peripheral not fed from latch");
    AST_INPUT_FEED: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !direction[n] |=> alt_in_o[n] == $past(pin_sample[n]))
      else $error("peripheral not fed from pin");
    AST_ALT_READBACK: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      s_axi_arvalid_i && s_axi_arready_o && (s_axi_araddr_i == OFFS_VALUE) && !direction[n]
      && alt_drv[n] |=> s_axi_rdata_o[n] == $past(alt_out_i[n]))
      else $error("read of alt-driven input lost alt level");
  end

  // ----------------------------------------
  // pin outputs and sampling
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_sample <= '0;
      pin_oe_o   <= '0;
      pin_o      <= '0;
      pull_up_o  <= '0;
      alt_in_o   <= '0;
    end else begin
      pin_sample <= pin_i;
      pin_oe_o   <= next_pin_oe;
      pin_o      <= next_pin_out;
      pull_up_o  <= next_pull;
      alt_in_o   <= next_alt_in;
    end
  end

  // ----------------------------------------
  // external interrupt group
  // ----------------------------------------
  // a low interrupt pin pins the NAND high, so edges on other pins vanish
  ext_irq_if irq_bus ();
  logic nand_group;
  logic next_ext_irq;

  assign nand_group           = ~&masked_pin;
  assign irq_bus.group_level  = ~nand_group;
  assign irq_bus.sens         = sens;
  assign irq_bus.sens_changed = sens_changed;
  assign irq_bus.vector_fetch = vector_fetch_i;
  assign next_ext_irq         = irq_bus.pending & ~irq_mask_i;

  ext_irq_sense u_sense (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .irq       (irq_bus.sense_side)
  );

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_irq_o <= 1'b0;
    end else begin
      ext_irq_o <= next_ext_irq;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic [DATA_W-1:0] rd_word;
  logic              rd_mapped;
  logic              ar_take;

  assign ar_take   = s_axi_arvalid_i & s_axi_arready_o;
  assign rd_mapped = (s_axi_araddr_i == OFFS_VALUE) | (s_axi_araddr_i == OFFS_DIR) |
                     (s_axi_araddr_i == OFFS_OPT) | (s_axi_araddr_i == OFFS_SENS);
  assign rd_word   = (s_axi_araddr_i == OFFS_VALUE) ? {24'h000000, read_value} :
                     (s_axi_araddr_i == OFFS_DIR)   ? {24'h000000, direction} :
                     (s_axi_araddr_i == OFFS_OPT)   ? {24'h000000, option} :
                     (s_axi_araddr_i == OFFS_SENS)  ? {30'h0, sens} :
                                                      32'h00000000;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_word;
        s_axi_rresp_o   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence seq_write_ready;
    aw_full && w_full && !s_axi_bvalid_o;
  endsequence

  sequence seq_value_read;
    ar_take && (s_axi_araddr_i == OFFS_VALUE);
  endsequence

  sequence seq_read_wait;
    s_axi_rvalid_o && !s_axi_rready_i;
  endsequence

  sequence seq_resp_wait;
    s_axi_bvalid_o && !s_axi_bready_i;
  endsequence

  AST_WRITE_RESP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    seq_write_ready |=> s_axi_bvalid_o ##0 !s_axi_awready_o && !s_axi_wready_o)
    else $error("write response missing");
  AST_VALUE_READ: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    seq_value_read |=> s_axi_rvalid_o && (s_axi_rdata_o[7:0] == $past(read_value)))
    else $error("value read returned wrong level");
  AST_LATCH_WRITE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_value |=> (port_latch == $past(w_data)) && (direction == $past(direction)))
    else $error("value write lost");
  AST_RESET_ZERO: assert property (@(posedge ref_clk_i)
    $past(reset_i) |-> (port_latch == 8'h00) && (direction == 8'h00) && (option == 8'h00))
    else $error("port registers not zero after reset");
  AST_IRQ_GATE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ext_irq_o |-> $past(irq_bus.pending) && !$past(irq_mask_i))
    else $error("request passed while masked");
  AST_NAND_MASK: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (|(irq_pin_en & ~pin_sample)) |-> !irq_bus.group_level)
    else $error("low interrupt pin did not mask group");
  AST_READ_ANSWER: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ar_take |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered next cycle");
  AST_READ_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    seq_read_wait |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read data dropped before taken");
  AST_RESP_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    seq_resp_wait |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before taken");
  AST_BAD_WRITE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    seq_write_ready ##0 !wr_mapped |=> (s_axi_bresp_o == RESP_SLVERR) && $stable(port_latch)
      && $stable(direction) && $stable(option) && $stable(sens))
    else $error("unmapped write changed state");
  AST_RESET_PINS: assert property (@(posedge ref_clk_i)
    $past(reset_i) |-> (pin_oe_o == '0) && (pull_up_o == '0) && (sens == RST_SENS))
    else $error("pins not floating inputs after reset");
  AST_IRQ_PASS: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    irq_bus.pending && !irq_mask_i |=> ext_irq_o)
    else $error("unmasked request did not reach cpu");
  AST_SENS_WRITE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_sens |=> sens == $past(next_sens))
    else $error("sensitivity write lost");
  AST_MODE_WRITE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_dir |=> (direction == $past(w_data)) && (port_latch == $past(port_latch)))
    else $error("direction write lost");
endmodule

// ==== testbench/pin_partner.sv ====
`timescale 1ns/1ps
module pin_partner (
  input  wire logic       ref_clk_i,  // cpu clock
  input  wire logic [7:0] drive_i,    // port drive value
  input  wire logic [7:0] oe_i,       // port drive enable
  input  wire logic [7:0] pull_up_i,  // port pull-up enable
  input  wire logic [7:0] ext_en_i,   // outside source active
  input  wire logic [7:0] ext_val_i,  // outside source level
  output logic      [7:0] level_o     // resolved pin level
);
  logic [7:0] drift;
  // a floating pin must not hold its last value
  always_ff @(posedge ref_clk_i) begin
    drift <= (drift === 8'h55) ? 8'hAA : 8'h55;
  end
  // outside source is weak, so the port's own driver wins a contest
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) level_o[i] = drive_i[i];
      else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
      else if (pull_up_i[i]) level_o[i] = 1'b1;
      else level_o[i] = drift[i];
    end
  end
endmodule

// ==== testbench/bidirectional_io_port_test.sv ====
`timescale 1ns/1ps
module bidirectional_io_port_test;
  import gpio_port_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        reset_i   = 1'b0;
  logic [7:0]  ext_en    = 8'hFF;
  logic [3:0]  wstrb     = 4'hF;
  logic [7:0]  awaddr    = 8'h00;
  logic [7:0]  araddr    = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic [7:0]  alt_en    = 8'h00;
  logic [7:0]  alt_drive = 8'h00;
  logic [7:0]  alt_out   = 8'h00;
  logic [7:0]  alt_od    = 8'h00;
  logic [7:0]  ext_val   = 8'hFF;
  logic        irq_mask  = 1'b0;
  logic        fetch     = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ext_irq;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0]  pin_lvl, pin_drv, pin_oe, pull_up, alt_in;
  int          error_cnt = 0;
  int          check_count = 0;
  int          m_lat, m_dir, m_opt, ad;

  gpio_port dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .pin_i(pin_lvl), .pin_o(pin_drv), .pin_oe_o(pin_oe),
    .pull_up_o(pull_up), .alt_en_i(alt_en), .alt_drive_i(alt_drive), .alt_out_i(alt_out),
    .alt_od_i(alt_od), .alt_in_o(alt_in), .irq_mask_i(irq_mask),
    .vector_fetch_i(fetch), .ext_irq_o(ext_irq));
  pin_partner ext (.ref_clk_i(ref_clk_i), .drive_i(pin_drv), .oe_i(pin_oe),
    .pull_up_i(pull_up), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_lvl));

  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic drive_ext(input logic [7:0] v);
    @(posedge ref_clk_i);
    ext_val <= v;
  endtask
  task automatic pulse_fetch();
    @(posedge ref_clk_i);
    fetch <= 1'b1;
    @(posedge ref_clk_i);
    fetch <= 1'b0;
  endtask
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 12 && ext_irq !== exp; i++) @(posedge ref_clk_i);
    chk(32'(ext_irq), 32'(exp), "ext_irq");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #200000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    reset_i <= 1'b1;
    void'($urandom(32'h40E0));
    ticks(4);
    reset_i <= 1'b0;
    rd_reg(OFFS_DIR);
    chk(rd, 32'(RST_DIR), "dir reset");
    rd_reg(OFFS_OPT);
    chk(rd, 32'(RST_OPT), "opt reset");
    chk(32'(pin_oe | pull_up), 32'h0, "reset floating");
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      m_lat = $urandom & 255;
      m_dir = $urandom & 255;
      m_opt = $urandom & 255;
      wr(OFFS_VALUE, m_lat);
      wr(OFFS_DIR, m_dir);
      wr(OFFS_OPT, m_opt);
      @(posedge ref_clk_i);
      ext_val <= 8'($urandom);
      alt_drive <= 8'($urandom);
      alt_out <= 8'($urandom);
      alt_od <= 8'($urandom);
      alt_en <= (k < 3) ? 8'h00 : 8'($urandom & ~(~m_dir & m_opt));
      ticks(4);
      ad = alt_en & alt_drive;
      // only pulled-up inputs may lose their outside source
      ext_en <= 8'($urandom | ~(~m_dir & m_opt & ~ad));
      ticks(3);
      chk(32'(pin_oe), (ad & (~alt_od | ~alt_out) | ~ad & m_dir & (m_opt | ~m_lat)) & 255,
          "oe");
      chk(32'(pin_drv), (ad & ~alt_od & alt_out | ~ad & m_dir & m_opt & m_lat) & 255,
          "drive");
      chk(32'(pull_up), ~m_dir & m_opt & ~ad & 255, "pull-up");
      chk(32'(alt_in & (m_dir | ~ad)),
          (m_dir & m_lat | ~m_dir & (ext_val | ~ext_en)) & (m_dir | ~ad) & 255,
          "alt in");
      rd_reg(OFFS_VALUE);
      chk(rd, (m_dir & m_lat | ~m_dir & ad & alt_out | ~m_dir & ~ad & (ext_val | ~ext_en)) & 255,
          "value read");
      rd_reg(OFFS_OPT);
      chk(rd, 32'(m_opt), "opt read");
    end
    $display("test pin modes done");
    wr(8'h10, 1);
    chk(32'(resp), 32'(RESP_SLVERR), "unmapped write");
    rd_reg(8'h11);
    chk({rd[29:0], resp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wstrb <= 4'hE;
    wr(OFFS_OPT, 0);
    chk(32'(resp), 32'(RESP_OKAY), "strobe-less write resp");
    wstrb <= 4'hF;
    rd_reg(OFFS_OPT);
    chk(rd, 32'(m_opt), "strobe-less write");
    $display("test unmapped done");
    @(posedge ref_clk_i);
    alt_en <= 8'h00;
    ext_en <= 8'hFF;
    ext_val <= 8'hFF;
    wr(OFFS_DIR, 0);
    wr(OFFS_OPT, 1);
    wr(OFFS_SENS, SENS_FALL);
    ticks(4);
    pulse_fetch();
    wait_irq(1'b0);
    drive_ext(8'hFE);
    wait_irq(1'b1);
    pulse_fetch();
    wait_irq(1'b0);
    @(posedge ref_clk_i);
    irq_mask <= 1'b1;
    drive_ext(8'hFF);
    ticks(3);
    drive_ext(8'hFE);
    ticks(8);
    chk(32'(ext_irq), 32'h0, "masked irq");
    @(posedge ref_clk_i);
    irq_mask <= 1'b0;
    wait_irq(1'b1);
    wr(OFFS_SENS, SENS_RISE);
    wait_irq(1'b0);
    drive_ext(8'hFF);
    wait_irq(1'b1);
    pulse_fetch();
    wait_irq(1'b0);
    drive_ext(8'hFD);
    wr(OFFS_OPT, 3);
    ticks(3);
    drive_ext(8'hFC);
    ticks(3);
    drive_ext(8'hFD);
    ticks(8);
    chk(32'(ext_irq), 32'h0, "grouped irq");
    drive_ext(8'hFF);
    wait_irq(1'b1);
    wr(OFFS_SENS, SENS_BOTH);
    wait_irq(1'b0);
    drive_ext(8'hFE);
    wait_irq(1'b1);
    pulse_fetch();
    wait_irq(1'b0);
    drive_ext(8'hFF);
    wait_irq(1'b1);
    wr(OFFS_SENS, SENS_FALL_LOW);
    wait_irq(1'b0);
    drive_ext(8'hFE);
    wait_irq(1'b1);
    pulse_fetch();
    ticks(3);
    chk(32'(ext_irq), 32'h1, "level irq");
    drive_ext(8'hFF);
    pulse_fetch();
    wait_irq(1'b0);
    $display("test interrupts done");
    close_out();
  end
endmodule
